// file: dds_pkg.sv
// Constants shared by the sine synthesizer datapath and its output FIFO.
// Assumes a single 100 MHz clock and a build-time spur-suppression target.
package dds_pkg;

    // Clock rate and the frequency resolution the accumulator must reach.
    localparam longint CLK_HZ = 100_000_000;
    localparam longint RES_HZ = 1;

    // Accumulator width is the ceiling of log2 of clock over resolution.
    localparam int PHASE_W = $clog2(CLK_HZ / RES_HZ);

    // Spur suppression target without dither, in dB, at 6 dB per address bit.
    localparam int SFDR_DB = 72;
    localparam int DB_PER_BIT = 6;
    localparam int ADDR_W = (SFDR_DB + DB_PER_BIT - 1) / DB_PER_BIT;

    // Dither buys two address bits, about 12 dB, for the same table.
    localparam int DITHER_BITS_SAVED = 2;
    localparam int SFDR_DITH_DB = SFDR_DB + DITHER_BITS_SAVED * DB_PER_BIT;
    localparam int ADDR_W_DITH_MIN = SFDR_DITH_DB / DB_PER_BIT - DITHER_BITS_SAVED;

    // Fractional bits dropped by the quantizer.
    localparam int FRAC_W = PHASE_W - ADDR_W;

    // Quarter-wave table: two quadrant bits, the rest index one quadrant.
    localparam int QUAD_W = 2;
    localparam int IDX_W = ADDR_W - QUAD_W;
    localparam int QTR_DEPTH = 2 ** IDX_W;
    localparam int FULL_DEPTH = 2 ** ADDR_W;

    // Stored sample width and peak amplitude.
    localparam int SAMP_W = 16;
    localparam longint SAMP_AMP = 32767;

    // Output FIFO depth and word width (cosine above sine).
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = 2 * SAMP_W;

    // Dither generator width, its reset seed and feedback taps.
    localparam int LFSR_W = 32;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 32'hACE1_1234;
    localparam logic [LFSR_W-1:0] LFSR_TAPS = 32'h8020_0003;

endpackage

// file: dds_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; depth a power of two.
`timescale 1ns/1ns
module dds_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Storage is written only when a word is accepted.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count move on accepted pushes and pops.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// file: dds_synth.sv
// Dithered phase-to-sine synthesizer: accumulator, dither, quantizer,
// quarter-wave sine/cosine table and a small output FIFO.
// Assumes one clock, synchronous inputs and a sink that may stall.
// A stalled sink freezes the whole pipeline, so no sample is ever dropped.
//
// Operation
// - The phase increment is an integer; fractional frequency parts are truncated.
// - Accumulator width is ceil(log2(clock over resolution)).
// - The table is addressed by reduced-precision phase, never the full accumulator.
// - The quantizer drops fractional low bits and keeps the upper phase bits.
// - Table storage is block or distributed memory, chosen at build time.
// - Without dither, address width is at least S/6 bits for S dB.
// - Wider samples do not lower truncation spurs; only a deeper table does.
// - Dither noise variance is about one integer phase LSB.
// - Dither is added to full-precision phase before quantizing.
// - With dither, S dB needs only S/6 minus two address bits.
// - Dither gives roughly 12 dB more spur-free range.
// - Output frequency is clock times increment over two to the width.
// - Top two quantized phase bits select the quadrant via waveform symmetry.
`timescale 1ns/1ns
module dds_synth
    import dds_pkg::*;
#(
    parameter bit TABLE_IN_BLOCK_MEM = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [PHASE_W-1:0] phase_inc,
    input wire logic dither_en,
    output logic out_valid,
    input wire logic out_ready,
    output logic [SAMP_W-1:0] out_sin,
    output logic [SAMP_W-1:0] out_cos
);

    // Build-time sizing checks on the accumulator and table.
    if (PHASE_W < $clog2(CLK_HZ / RES_HZ)) begin : g_chk_phase
        $error("Accumulator too narrow for the frequency resolution.");
    end
    if (ADDR_W * DB_PER_BIT < SFDR_DB) begin : g_chk_addr
        $error("Table too shallow for the truncation spur target.");
    end
    if (ADDR_W < ADDR_W_DITH_MIN) begin : g_chk_dith
        $error("Table too shallow for the dithered spur target.");
    end

    logic adv;
    logic f_in_ready;
    logic [PHASE_W-1:0] acc_q;
    logic [LFSR_W-1:0] lfsr_q;
    logic [PHASE_W-1:0] dith_term;
    logic [PHASE_W-1:0] ph_dith;
    logic [ADDR_W-1:0] addr_q;
    logic v1_q;
    logic [ADDR_W-1:0] caddr;
    logic [IDX_W-1:0] sidx;
    logic [IDX_W-1:0] cidx;
    logic sneg2_q;
    logic cneg2_q;
    logic v2_q;
    logic [SAMP_W-1:0] smag;
    logic [SAMP_W-1:0] cmag;
    logic [SAMP_W-1:0] sin3_q;
    logic [SAMP_W-1:0] cos3_q;
    logic v3_q;
    logic [SAMP_W-1:0] rom [0:QTR_DEPTH-1];

    // Quarter sine at the middle of each table step, so mirroring is exact.
    function automatic logic [SAMP_W-1:0] qsine(input int i);
        longint a;
        longint u;
        longint v;
        a = 2 * i + 1;
        u = a * (4 * QTR_DEPTH - a);
        v = SAMP_AMP * 16 * u / (5 * 16 * longint'(QTR_DEPTH) * QTR_DEPTH - 4 * u);
        return v[SAMP_W-1:0];
    endfunction

    // The table contents are fixed when the design is built.
    initial begin
        for (int i = 0; i < QTR_DEPTH; i++) begin
            rom[i] = qsine(i);
        end
    end

    // The whole pipeline moves when its last stage is empty or the FIFO has room.
    assign adv = !v3_q || f_in_ready;

    // Phase accumulator wraps modulo two to its width; increment taken as is.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc_q <= '0;
        end else if (adv) begin
            acc_q <= acc_q + phase_inc;
        end
    end

    // Galois LFSR steps once per sample, whether or not dither is used.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lfsr_q <= LFSR_SEED;
        end else if (adv) begin
            lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? LFSR_TAPS : '0);
        end
    end

    // Dither spans one integer LSB of the quantized phase.
    assign dith_term = dither_en ? PHASE_W'(lfsr_q[FRAC_W-1:0]) : '0;
    assign ph_dith = acc_q + dith_term;

    // Quantizer keeps only the upper bits as the table address.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            addr_q <= '0;
            v1_q <= 1'b0;
        end else if (adv) begin
            addr_q <= ph_dith[PHASE_W-1 -: ADDR_W];
            v1_q <= 1'b1;
        end
    end

    // Cosine is the sine a quarter cycle ahead.
    assign caddr = addr_q + ADDR_W'(QTR_DEPTH);

    // Odd quadrants read the quarter table mirrored.
    assign sidx = addr_q[IDX_W] ? ~addr_q[IDX_W-1:0] : addr_q[IDX_W-1:0];
    assign cidx = caddr[IDX_W] ? ~caddr[IDX_W-1:0] : caddr[IDX_W-1:0];

    // Sign of each output follows the upper half of the cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sneg2_q <= 1'b0;
            cneg2_q <= 1'b0;
            v2_q <= 1'b0;
        end else if (adv) begin
            sneg2_q <= addr_q[ADDR_W-1];
            cneg2_q <= caddr[ADDR_W-1];
            v2_q <= v1_q;
        end
    end

    // Table read: registered output in block memory, registered index otherwise.
    // Both builds have the same latency, so either one can be chosen at build time.
    if (TABLE_IN_BLOCK_MEM) begin : g_bram
        logic [SAMP_W-1:0] sdat_q;
        logic [SAMP_W-1:0] cdat_q;
        always_ff @(posedge clk) begin
            if (adv) begin
                sdat_q <= rom[sidx];
                cdat_q <= rom[cidx];
            end
        end
        assign smag = sdat_q;
        assign cmag = cdat_q;
    end else begin : g_dram
        logic [IDX_W-1:0] sidx_q;
        logic [IDX_W-1:0] cidx_q;
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                sidx_q <= '0;
                cidx_q <= '0;
            end else if (adv) begin
                sidx_q <= sidx;
                cidx_q <= cidx;
            end
        end
        assign smag = rom[sidx_q];
        assign cmag = rom[cidx_q];
    end

    // Final stage applies the quadrant sign to the table magnitude.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sin3_q <= '0;
            cos3_q <= '0;
            v3_q <= 1'b0;
        end else if (adv) begin
            sin3_q <= sneg2_q ? -smag : smag;
            cos3_q <= cneg2_q ? -cmag : cmag;
            v3_q <= v2_q;
        end
    end

    // Samples queue here; a full FIFO stalls the pipeline through adv.
    dds_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(v3_q),
        .in_ready(f_in_ready),
        .in_data({cos3_q, sin3_q}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_cos, out_sin})
    );

    // Checks on the datapath, all on the one clock.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Accumulator takes the old value plus the increment, modulo the width.
    property p_acc_step;
        adv |=> acc_q == PHASE_W'($past(acc_q) + $past(phase_inc));
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("Accumulator step wrong.");

    // A stall freezes the accumulator and the dither generator.
    property p_stall_hold;
        !adv |=> $stable(acc_q) && $stable(lfsr_q);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("State moved in stall.");

    // Without dither the address is exactly the top phase bits.
    property p_quant;
        adv && !dither_en |=> addr_q == $past(acc_q[PHASE_W-1 -: ADDR_W]);
    endproperty
    a_quant: assert property (p_quant) else $error("Quantized address wrong.");

    // With dither the address rises by no more than one step.
    property p_dith_span;
        adv && dither_en |=>
            (ADDR_W'(addr_q - $past(acc_q[PHASE_W-1 -: ADDR_W])) <= ADDR_W'(1));
    endproperty
    a_dith_span: assert property (p_dith_span) else $error("Dither too large.");

    // The dither generator changes every sample and never locks at zero.
    property p_lfsr_run;
        adv |=> lfsr_q != $past(lfsr_q) && lfsr_q != '0;
    endproperty
    a_lfsr_run: assert property (p_lfsr_run) else $error("Dither generator stuck.");

    // Upper-half phase gives a non-positive sine two stages later.
    property p_sin_sign;
        adv && v1_q && addr_q[ADDR_W-1] ##1 adv [*2] |-> sin3_q[SAMP_W-1] || sin3_q == '0;
    endproperty
    a_sin_sign: assert property (p_sin_sign) else $error("Sine sign wrong.");

    // Quadrant zero produces a non-negative cosine two stages later.
    property p_cos_sign;
        adv && v1_q && addr_q[ADDR_W-1 -: QUAD_W] == '0 ##1 adv [*2] |->
            !cos3_q[SAMP_W-1];
    endproperty
    a_cos_sign: assert property (p_cos_sign) else $error("Cosine sign wrong.");

    // A sample refused by a full FIFO waits unchanged.
    property p_backpress;
        v3_q && !f_in_ready |=> v3_q && $stable(sin3_q) && $stable(cos3_q);
    endproperty
    a_backpress: assert property (p_backpress) else $error("Sample lost.");

    // With dither off the quantizer sees the bare accumulator.
    property p_dith_off;
        !dither_en |-> ph_dith == acc_q;
    endproperty
    a_dith_off: assert property (p_dith_off) else $error("Dither leaks.");

    // Dither alone never reaches the integer phase bits.
    property p_dith_lsb;
        dith_term[PHASE_W-1:FRAC_W] == '0;
    endproperty
    a_dith_lsb: assert property (p_dith_lsb) else $error("Dither too wide.");

    // The address is the top bits of the dithered phase, taken before quantizing.
    property p_quant_dith;
        adv |=> addr_q == $past(ph_dith[PHASE_W-1 -: ADDR_W]);
    endproperty
    a_quant_dith: assert property (p_quant_dith) else $error("Address wrong.");

    // Sine and cosine indexes mirror each other in every quadrant.
    property p_quad_mirror;
        sidx == ~cidx;
    endproperty
    a_quad_mirror: assert property (p_quad_mirror) else $error("Mirror wrong.");

    // The cosine address sits one quadrant ahead with the same index bits.
    property p_cos_quad;
        caddr[IDX_W-1:0] == addr_q[IDX_W-1:0] &&
            caddr[ADDR_W-1 -: QUAD_W] == QUAD_W'(addr_q[ADDR_W-1 -: QUAD_W] + 1'b1);
    endproperty
    a_cos_quad: assert property (p_cos_quad) else $error("Cosine address wrong.");

    // Valid bits march one stage per advance.
    property p_pipe_valid;
        adv |=> v2_q == $past(v1_q) && v3_q == $past(v2_q);
    endproperty
    a_pipe_valid: assert property (p_pipe_valid) else $error("Valid lost.");

    // The pipeline only stalls while a sample waits at the output.
    property p_stall_cause;
        !adv |-> out_valid;
    endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("Idle stall.");

    // A waiting output word stays put until the sink takes it.
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_sin) && $stable(out_cos);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("Output moved.");

    // The first sample after reset starts from phase zero.
    property p_first_phase;
        $rose(v1_q) |-> addr_q == '0;
    endproperty
    a_first_phase: assert property (p_first_phase) else $error("Start phase wrong.");

endmodule

// file: test_dds_synth.sv
// Self-checking testbench for the dithered sine synthesizer and its output FIFO.
// Assumes the dds_pkg constants and a 100 MHz clock; inputs change on falling edges.
`timescale 1ns/1ns
module test_dds_synth
    import dds_pkg::*;
;
    localparam int LIMIT = 5000;
    localparam int TOL = 100;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [PHASE_W-1:0] phase_inc = 27'h200_0000;
    logic dither_en = 1'b0;
    logic out_ready = 1'b0;
    logic out_valid, out_valid2;
    logic [SAMP_W-1:0] out_sin, out_cos, out_sin2, out_cos2;
    logic [FIFO_W-1:0] words [0:63];
    logic [FIFO_W-1:0] base_w [0:63];
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    // Block-memory table build under test.
    dds_synth #(.TABLE_IN_BLOCK_MEM(1'b1)) DUT (.clk(clk), .rst_b(rst_b),
        .phase_inc(phase_inc), .dither_en(dither_en), .out_valid(out_valid),
        .out_ready(out_ready), .out_sin(out_sin), .out_cos(out_cos));

    // Distributed-memory build run in lockstep; its samples must match.
    dds_synth #(.TABLE_IN_BLOCK_MEM(1'b0)) DUT_DIST (.clk(clk), .rst_b(rst_b),
        .phase_inc(phase_inc), .dither_en(dither_en), .out_valid(out_valid2),
        .out_ready(out_ready), .out_sin(out_sin2), .out_cos(out_cos2));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Cuts a hung run short and reports it as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [FIFO_W-1:0] seen, input logic [FIFO_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ideal sample at the half-step point of a full-wave table address.
    function automatic int esin(input int addr);
        return $rtoi(SAMP_AMP * $sin(2.0 * 3.14159265358979 * (addr + 0.5) / FULL_DEPTH));
    endfunction

    // The table is an approximation, so samples are judged within a tolerance.
    task automatic check_near(input logic [SAMP_W-1:0] seen, input int e);
        int d;
        d = int'($signed(seen)) - e;
        if (^seen !== 1'bx && d <= TOL && d >= -TOL)
            check({16'h0, seen}, {16'h0, seen});
        else
            check({16'h0, seen}, {16'h0, e[15:0]});
    endtask

    // Restarts the datapath from phase zero with a new step and dither mode.
    task automatic do_reset(input logic [PHASE_W-1:0] inc, input logic dith);
        @(negedge clk);
        rst_b = 1'b0;
        out_ready = 1'b0;
        phase_inc = inc;
        dither_en = dith;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
    endtask

    // Pops n samples with the sink always ready; each word is read just before its pop edge.
    task automatic capture(input int n);
        int k;
        int guard;
        k = 0;
        guard = 0;
        out_ready = 1'b1;
        while (k < n && guard < 300) begin
            check(out_valid2, out_valid);
            if (out_valid === 1'b1) begin
                words[k] = {out_cos, out_sin};
                check({out_cos2, out_sin2}, {out_cos, out_sin});
                k++;
            end
            guard++;
            @(negedge clk);
        end
        check(k, n);
        out_ready = 1'b0;
    endtask

    // Compares captured samples with the ideal wave at the truncated phase.
    task automatic check_seq(input logic [PHASE_W-1:0] inc, input int n);
        logic [PHASE_W-1:0] ph;
        int a;
        ph = '0;
        for (int k = 0; k < n; k++) begin
            a = int'(ph >> FRAC_W);
            check_near(words[k][SAMP_W-1:0], esin(a));
            check_near(words[k][FIFO_W-1:SAMP_W], esin(a + QTR_DEPTH));
            ph = ph + inc;
        end
    endtask

    task automatic test_sizing();
        check(PHASE_W, 27);
        check(ADDR_W >= 12, 1);
        check(ADDR_W_DITH_MIN, 12);
        check(SFDR_DITH_DB - SFDR_DB, 12);
        $display("test sizing done");
    endtask

    task automatic test_reset();
        check(out_valid, 1'b0);
        rst_b = 1'b1;
        repeat (3) begin
            @(negedge clk);
            check(out_valid, 1'b0);
        end
        @(negedge clk);
        check(out_valid, 1'b1);
        capture(4);
        check_seq(phase_inc, 4);
        $display("test reset done");
    endtask

    task automatic test_steps();
        logic [PHASE_W-1:0] incs [0:4];
        incs = '{27'h200_0000, 27'h600_0000, 27'h123_4567, 27'h000_8000, 27'h7FF_FFFF};
        foreach (incs[i]) begin
            do_reset(incs[i], 1'b0);
            capture(12);
            check_seq(incs[i], 12);
        end
        $display("test steps done");
    endtask

    task automatic test_stall();
        logic [FIFO_W-1:0] w;
        do_reset(27'h200_0000, 1'b0);
        repeat (20) @(negedge clk);
        check(out_valid, 1'b1);
        w = {out_cos, out_sin};
        repeat (10) @(negedge clk);
        check({out_cos, out_sin}, w);
        capture(10);
        check_seq(27'h200_0000, 10);
        $display("test stall done");
    endtask

    // A half-address step: even samples sit on an address, odd ones halfway.
    task automatic test_dither();
        int nchg;
        nchg = 0;
        do_reset(27'h000_4000, 1'b0);
        capture(32);
        for (int k = 0; k < 32; k++) begin
            base_w[k] = words[k];
            if (k % 2 == 1)
                check(words[k], words[k - 1]);
        end
        do_reset(27'h000_4000, 1'b1);
        capture(32);
        for (int k = 0; k < 31; k++) begin
            if (k % 2 == 0) begin
                check(words[k], base_w[k]);
            end else begin
                if (words[k] !== base_w[k])
                    nchg++;
                check(words[k], (words[k] === base_w[k + 1]) ? base_w[k + 1] : base_w[k]);
            end
        end
        check(nchg > 0, 1'b1);
        $display("test dither done");
    endtask

    // Main sequence: 12 cycles of reset, then each scenario in turn.
    initial begin
        repeat (12) @(negedge clk);
        test_sizing();
        test_reset();
        test_steps();
        test_stall();
        test_dither();
        conclude();
    end
endmodule
